// *** pkg/port_strobe_defines.svh ***
// constants for the port access strobe block
// Summary of operation
// RL1: strobes pulse on port reads and writes only while strobe enable is set
// RL2: each strobe pulse lasts two processor clock cycles, unless a new access of its own kind restarts the sequence and cuts it short
// RL3: write strobe asserts two cycles after port update, active two cycles
// RL4: read returns port pins latched three cycles before read strobe asserts
// RL5: read strobe asserts three cycles after the read, active two cycles
// RL6: nothing is sampled because the read strobe asserts; prefetch hint only
// RL7: external logic holds port input until the read strobe has pulsed
// RL8: external logic uses read strobe to stage next byte before next read
// RL9: with enable clear, port accesses leave both strobes deasserted
`ifndef PORT_STROBE_DEFINES_SVH
`define PORT_STROBE_DEFINES_SVH
`define PS_WR_DELAY 3'h2
`define PS_RD_DELAY 3'h3
`define PS_PULSE_LEN 3'h2
`define PS_DATA_RST 8'h00
`define PS_CNT_RST 3'h0
`endif

// *** pkg/port_strobe_pkg.sv ***
// types for the port access strobe block
package port_strobe_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_PULSE = 3'b100
   } strobe_state_t;

   typedef struct packed {
      strobe_state_t st;
      logic [2:0] cnt;
   } strobe_seq_t;

   typedef struct packed {
      logic [7:0] pin_s1;
      logic [7:0] pin_s2;
      logic [7:0] rd_data;
      logic [7:0] out_data;
      strobe_seq_t wr;
      strobe_seq_t rd;
   } port_state_t;
endpackage

// *** design/port_access_strobe.sv ***
// read/write strobe generator for the third io port
`timescale 1ns/1ps
`include "port_strobe_defines.svh"
module port_access_strobe
   import port_strobe_pkg::*;
(
   input wire logic clk_i, // processor clock output rate
   input wire logic sys_rst_i, // sync reset, active high
   input wire logic port_strobe_enable_bit_i, // strobe enable control bit
   input wire logic cpu_wr_i, // processor writes the port, one cycle
   input wire logic [7:0] cpu_wdata_i, // write data
   input wire logic cpu_rd_i, // processor reads the port, one cycle
   output logic [7:0] cpu_rdata_o, // data returned by the last read
   input wire logic [7:0] third_io_port_pin_i, // port pins from outside
   output logic [7:0] third_io_port_o, // port output latch
   output logic rd_strobe_n_o, // read strobe, active low
   output logic wr_strobe_n_o // write strobe, active low
);
   port_state_t s_r;
   port_state_t s_nxt;

   // a new access restarts the sequence; back-to-back accesses stretch nothing
   function automatic strobe_seq_t step(strobe_seq_t q, logic start, logic [2:0] dly);
      strobe_seq_t n;
      n = q;
      if (start)
      begin
         n.st = ST_WAIT;
         n.cnt = dly - 3'h1;
      end
      else
      begin
         case (q.st)
            ST_WAIT:
            begin
               if (q.cnt == 3'h0)
               begin
                  n.st = ST_PULSE;
                  n.cnt = `PS_PULSE_LEN - 3'h1;
               end
               else
                  n.cnt = q.cnt - 3'h1;
            end
            ST_PULSE:
            begin
               if (q.cnt == 3'h0)
                  n.st = ST_IDLE;
               else
                  n.cnt = q.cnt - 3'h1;
            end
            default:
            begin
               n.st = ST_IDLE;
               n.cnt = 3'h0;
            end
         endcase
      end
      return n;
   endfunction

   // one decode for both pins, so they cannot drift apart
   function automatic logic strobe_n(strobe_seq_t q);
      return !(q.st == ST_PULSE);
   endfunction

   function automatic strobe_seq_t seq_idle();
      strobe_seq_t n;
      n.st = ST_IDLE;
      n.cnt = `PS_CNT_RST;
      return n;
   endfunction

   always_comb
   begin
      s_nxt = s_r;
      // two flops: the pins move with no regard to this clock
      s_nxt.pin_s1 = third_io_port_pin_i;
      s_nxt.pin_s2 = s_r.pin_s1;
      if (cpu_wr_i)
         s_nxt.out_data = cpu_wdata_i;
      // read data taken at the read itself, three cycles ahead of the strobe
      if (cpu_rd_i)
         s_nxt.rd_data = s_r.pin_s2; // RL4 RL6
      s_nxt.wr = step(s_r.wr, cpu_wr_i && port_strobe_enable_bit_i, `PS_WR_DELAY); // RL1 RL3 RL9
      s_nxt.rd = step(s_r.rd, cpu_rd_i && port_strobe_enable_bit_i, `PS_RD_DELAY); // RL1 RL5 RL9
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         s_r.pin_s1 <= `PS_DATA_RST;
         s_r.pin_s2 <= `PS_DATA_RST;
         s_r.rd_data <= `PS_DATA_RST;
         s_r.out_data <= `PS_DATA_RST;
         s_r.wr <= seq_idle();
         s_r.rd <= seq_idle();
      end
      else
         s_r <= s_nxt;
   end

   assign cpu_rdata_o = s_r.rd_data;
   assign third_io_port_o = s_r.out_data;
   assign wr_strobe_n_o = strobe_n(s_r.wr); // RL2
   assign rd_strobe_n_o = strobe_n(s_r.rd); // RL2

   // a property samples the flops one edge after the edge that loads them

   property p_wr_quiet;
      @(posedge clk_i) disable iff (sys_rst_i)
      cpu_wr_i && port_strobe_enable_bit_i |=> wr_strobe_n_o[*2];
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("write strobe too early"); // RL3

   property p_wr_timing;
      @(posedge clk_i) disable iff (sys_rst_i)
      cpu_wr_i && port_strobe_enable_bit_i ##1 !cpu_wr_i[*3]
         |-> !wr_strobe_n_o ##1 !wr_strobe_n_o ##1 wr_strobe_n_o;
   endproperty
   a_wr_timing: assert property (p_wr_timing) else $error("write strobe timing wrong"); // RL3

   property p_rd_quiet;
      @(posedge clk_i) disable iff (sys_rst_i)
      cpu_rd_i && port_strobe_enable_bit_i |=> rd_strobe_n_o[*3];
   endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read strobe too early"); // RL5

   property p_rd_timing;
      @(posedge clk_i) disable iff (sys_rst_i)
      cpu_rd_i && port_strobe_enable_bit_i ##1 !cpu_rd_i[*4]
         |-> !rd_strobe_n_o ##1 !rd_strobe_n_o ##1 rd_strobe_n_o;
   endproperty
   a_rd_timing: assert property (p_rd_timing) else $error("read strobe timing wrong"); // RL5

   property p_pulse_len;
      @(posedge clk_i) disable iff (sys_rst_i)
      $fell(rd_strobe_n_o) && !cpu_rd_i |=> !rd_strobe_n_o ##1 rd_strobe_n_o;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("read pulse not two cycles"); // RL2

   property p_wr_len;
      @(posedge clk_i) disable iff (sys_rst_i)
      $fell(wr_strobe_n_o) && !cpu_wr_i |=> !wr_strobe_n_o ##1 wr_strobe_n_o;
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("write pulse not two cycles"); // RL2

   property p_rd_low_max;
      @(posedge clk_i) disable iff (sys_rst_i)
      !rd_strobe_n_o ##1 !rd_strobe_n_o |=> rd_strobe_n_o;
   endproperty
   a_rd_low_max: assert property (p_rd_low_max) else $error("read strobe low too long"); // RL2

   property p_wr_low_max;
      @(posedge clk_i) disable iff (sys_rst_i)
      !wr_strobe_n_o ##1 !wr_strobe_n_o |=> wr_strobe_n_o;
   endproperty
   a_wr_low_max: assert property (p_wr_low_max) else $error("write strobe low too long"); // RL2

   property p_disabled;
      @(posedge clk_i) disable iff (sys_rst_i)
      !port_strobe_enable_bit_i[*6] |-> rd_strobe_n_o && wr_strobe_n_o;
   endproperty
   a_disabled: assert property (p_disabled) else $error("strobe while disabled"); // RL9

   property p_wr_masked;
      @(posedge clk_i) disable iff (sys_rst_i)
      !port_strobe_enable_bit_i[*5] |-> wr_strobe_n_o;
   endproperty
   a_wr_masked: assert property (p_wr_masked) else $error("write strobe while disabled"); // RL9

   property p_enable_gate;
      @(posedge clk_i) disable iff (sys_rst_i)
      $fell(wr_strobe_n_o)
         |-> $past(cpu_wr_i, 3) && $past(port_strobe_enable_bit_i, 3);
   endproperty
   a_enable_gate: assert property (p_enable_gate) else $error("write strobe without enable"); // RL1

   property p_rd_gate;
      @(posedge clk_i) disable iff (sys_rst_i)
      $fell(rd_strobe_n_o)
         |-> $past(cpu_rd_i, 4) && $past(port_strobe_enable_bit_i, 4);
   endproperty
   a_rd_gate: assert property (p_rd_gate) else $error("read strobe without enable"); // RL1

   // pins reach the read latch through both sync flops, so reset must be gone
   property p_rd_data;
      @(posedge clk_i) disable iff (sys_rst_i)
      cpu_rd_i && !$past(sys_rst_i) && !$past(sys_rst_i, 2)
         |=> cpu_rdata_o == $past(third_io_port_pin_i, 3);
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read data not latched value"); // RL4

   property p_rd_stable;
      @(posedge clk_i) disable iff (sys_rst_i)
      !cpu_rd_i |=> $stable(cpu_rdata_o);
   endproperty
   a_rd_stable: assert property (p_rd_stable) else $error("read data moved without read"); // RL6

   property p_rd_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      !rd_strobe_n_o |-> $stable(cpu_rdata_o);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved in strobe"); // RL6

   property p_port_out;
      @(posedge clk_i) disable iff (sys_rst_i)
      cpu_wr_i |=> third_io_port_o == $past(cpu_wdata_i);
   endproperty
   a_port_out: assert property (p_port_out) else $error("port latch not written"); // RL3

   property p_out_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      !cpu_wr_i |=> $stable(third_io_port_o);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("port latch moved"); // RL3

   property p_reset_idle;
      @(posedge clk_i)
      sys_rst_i |=> rd_strobe_n_o && wr_strobe_n_o
         && cpu_rdata_o == `PS_DATA_RST && third_io_port_o == `PS_DATA_RST;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset"); // RL1

   // both strobes low at once needs overlapping read and write
   c_write: cover property (@(posedge clk_i) $fell(wr_strobe_n_o));
   c_read: cover property (@(posedge clk_i) $fell(rd_strobe_n_o));
   c_both: cover property (@(posedge clk_i) !rd_strobe_n_o && !wr_strobe_n_o);
   c_masked: cover property (@(posedge clk_i)
      (cpu_wr_i || cpu_rd_i) && !port_strobe_enable_bit_i);
   c_restart: cover property (@(posedge clk_i) cpu_rd_i && !rd_strobe_n_o);
endmodule // port_access_strobe

// *** sim/port_feeder.sv ***
// external logic model driving the port pins
`timescale 1ns/1ps
module port_feeder
(
   input wire logic clk_i, // clock
   input wire logic rd_strobe_n_i, // read strobe, active low
   input wire logic [7:0] next_i, // byte staged next
   output logic [7:0] pin_o // port pins
);
   logic seen_r = 1'b0;
   initial pin_o = 8'h00;
   // byte held until the pulse ends, then the next one is staged
   always @(posedge clk_i)
   begin
      seen_r <= !rd_strobe_n_i;
      if (seen_r && rd_strobe_n_i)
         pin_o <= next_i;
   end
endmodule // port_feeder

// *** sim/testbench.sv ***
// self-checking bench for the port access strobe block
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [7:0] nxt = 8'h00;
   logic [7:0] pin, rdat, pout;
   logic rs_n, ws_n;
   logic [31:0] seed = 32'h0000_07c2;
   int errors = 0;
   int n_checks = 0;
   always #20 clk = ~clk;
   port_access_strobe i_port_access_strobe (.clk_i(clk), .sys_rst_i(rst),
      .port_strobe_enable_bit_i(en), .cpu_wr_i(wr), .cpu_wdata_i(wd), .cpu_rd_i(rd),
      .cpu_rdata_o(rdat), .third_io_port_pin_i(pin), .third_io_port_o(pout),
      .rd_strobe_n_o(rs_n), .wr_strobe_n_o(ws_n));
   port_feeder i_port_feeder (.clk_i(clk), .rd_strobe_n_i(rs_n), .next_i(nxt), .pin_o(pin));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // upper nibble: first low cycle, lower: cycles low
   function automatic logic [7:0] exp_stb(input logic op, input logic e);
      return e ? (op ? 8'h22 : 8'h32) : 8'h00;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic access(input logic op, input logic e);
      logic [7:0] s;
      logic [7:0] pexp;
      s = 8'h00;
      pexp = pin;
      @(posedge clk);
      en <= e;
      wr <= op;
      rd <= !op;
      wd <= seed[7:0];
      nxt <= seed[15:8];
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      for (int i = 1; i < 8; i++)
      begin
         @(posedge clk);
         #1;
         if ((op ? ws_n : rs_n) !== 1'b1)
         begin
            if (s[7:4] == 4'h0)
               s[7:4] = i[3:0];
            s[3:0] = s[3:0] + 4'h1;
         end
      end
      chk(s, exp_stb(op, e));
      chk(op ? pout : rdat, op ? seed[7:0] : pexp);
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 24; i++)
      begin
         seed = xs(seed);
         access(i < 4 ? i[0] : seed[16], i < 4 ? i[1] : seed[17]);
      end
      end_of_test();
   end
   initial
   begin
      #20000;
      errors++;
      end_of_test();
   end
endmodule // testbench
